// ---- include/dacm_pkg.sv ----
/*
  Constants shared by the dual alarm condition monitor: register offsets,
  field positions, reset values and source codes.
  Assumes the register port carries 16-bit words at even byte addresses.
*/
package dacm_pkg;

  // register byte offsets (low byte of each 16-bit word)
  localparam logic [6:0] OFS_ALARM_ONE_THRESHOLD    = 7'h26;
  localparam logic [6:0] OFS_ALARM_TWO_THRESHOLD    = 7'h28;
  localparam logic [6:0] OFS_ALARM_ONE_SAMPLE_COUNT = 7'h2A;
  localparam logic [6:0] OFS_ALARM_TWO_SAMPLE_COUNT = 7'h2C;
  localparam logic [6:0] OFS_ALARM_CONTROL          = 7'h2E;
  localparam logic [6:0] OFS_STATUS                 = 7'h3C;

  // reset values
  localparam logic [15:0] RST_THRESHOLD    = 16'h0000;
  localparam logic [15:0] RST_SAMPLE_COUNT = 16'h0000;
  localparam logic [15:0] RST_CONTROL      = 16'h0000;

  // threshold field layout
  localparam int THR_DIR_BIT = 15;
  localparam int THR_MAG_MSB = 13;

  // control field layout
  localparam int CTL_SRC_TWO_LSB = 12;
  localparam int CTL_SRC_ONE_LSB = 8;
  localparam int CTL_SRC_W       = 4;
  localparam int CTL_ROC_TWO_BIT = 7;
  localparam int CTL_ROC_ONE_BIT = 6;
  localparam int CTL_FILT_BIT    = 4;
  localparam int CTL_OUT_EN_BIT  = 2;
  localparam int CTL_OUT_POL_BIT = 1;
  localparam int CTL_OUT_SEL_BIT = 0;

  // status field layout
  localparam int STS_ALARM_ONE_BIT = 8;
  localparam int STS_ALARM_TWO_BIT = 9;

  // source select codes
  localparam logic [3:0] SRC_DISABLED = 4'h0;
  localparam logic [3:0] SRC_LAST     = 4'hB;

endpackage

// ---- design/dacm_alarm_chan.sv ----
/*
  One alarm evaluator: static level or averaged rate-of-change comparison
  of the selected source sample against a signed threshold magnitude.
  Assumes i_update is a one-cycle pulse per output register update and
  that i_sample is stable in that cycle.
*/
`timescale 1ns/1ps
module dacm_alarm_chan #(
  parameter int DW = 14
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  input  wire logic          i_update,
  input  wire logic          i_enable,
  input  wire logic          i_roc,
  input  wire logic          i_greater,
  input  wire logic [DW-1:0] i_thr,
  input  wire logic [15:0]   i_count,
  input  wire logic [DW-1:0] i_sample,
  output logic               o_eval,
  output logic               o_cond
);

  // samples wider than the threshold field cannot be compared
  if (DW < 2 || DW > 14) begin : g_bad_dw
    $error("dacm_alarm_chan: DW must be 2..14");
  end

  logic [DW-1:0]      prev_reg, prev_next;
  logic               have_prev_reg, have_prev_next;
  logic signed [47:0] acc_reg, acc_next;
  logic [15:0]        cnt_reg, cnt_next;
  logic               eval_reg, eval_next;
  logic               cond_reg, cond_next;

  logic signed [47:0] thr_s, smp_s, delta_s, sum_s, lim_s;
  logic [16:0]        n_eff;

  // next state: one evaluation per update; roc compares sum with thr*n
  // rather than dividing, which gives the same verdict for the mean
  always_comb begin
    thr_s   = 48'(signed'(i_thr));
    smp_s   = 48'(signed'(i_sample));
    delta_s = smp_s - 48'(signed'(prev_reg));
    sum_s   = acc_reg + delta_s;
    n_eff   = (i_count == 16'h0000) ? 17'h00001 : {1'b0, i_count};
    lim_s   = thr_s * 48'(signed'({1'b0, n_eff}));
    prev_next      = prev_reg;
    have_prev_next = have_prev_reg;
    acc_next       = acc_reg;
    cnt_next       = cnt_reg;
    eval_next      = 1'b0;
    cond_next      = cond_reg;
    if (!i_enable) begin
      have_prev_next = 1'b0;
      acc_next       = '0;
      cnt_next       = 16'h0000;
      cond_next      = 1'b0;
    end else if (i_update) begin
      prev_next      = i_sample;
      have_prev_next = 1'b1;
      eval_next      = 1'b1;
      if (!i_roc) begin
        cond_next = i_greater ? (smp_s > thr_s) : (smp_s < thr_s);
        acc_next  = '0;
        cnt_next  = 16'h0000;
      end else if (have_prev_reg) begin
        if ({1'b0, cnt_reg} + 17'h00001 >= n_eff) begin
          cond_next = i_greater ? (sum_s > lim_s) : (sum_s < lim_s);
          acc_next  = '0;
          cnt_next  = 16'h0000;
        end else begin
          acc_next = sum_s;
          cnt_next = cnt_reg + 16'h0001;
        end
      end
    end
  end

  // state registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev_reg      <= '0;
      have_prev_reg <= 1'b0;
      acc_reg       <= '0;
      cnt_reg       <= 16'h0000;
      eval_reg      <= 1'b0;
      cond_reg      <= 1'b0;
    end else begin
      prev_reg      <= prev_next;
      have_prev_reg <= have_prev_next;
      acc_reg       <= acc_next;
      cnt_reg       <= cnt_next;
      eval_reg      <= eval_next;
      cond_reg      <= cond_next;
    end
  end

  assign o_eval = eval_reg;
  assign o_cond = cond_reg;

  a_static_greater: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_update && i_enable && !i_roc && i_greater &&
    (signed'(i_sample) > signed'(i_thr)) |=> o_cond && o_eval)
    else $error("static greater compare missed");

  a_static_less: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_update && i_enable && !i_roc && !i_greater &&
    (signed'(i_sample) >= signed'(i_thr)) |=> !o_cond)
    else $error("static less compare fired wrongly");

endmodule // dacm_alarm_chan

// ---- design/dacm_monitor.sv ----
/*
  Dual alarm condition monitor: alarm configuration registers, source
  selection, two alarm evaluators, sticky status flags and the alarm pin
  drive onto one of two general-purpose lines.
  Assumes sources and update pulse come from logic on i_ref_clk, and that
  the serial port logic presents decoded 16-bit register accesses.
*/
`timescale 1ns/1ps

// Behaviour
// - two alarms run independently and flag when their source meets the set condition.
// - control bit 4 picks filtered source data when set, unfiltered when clear.
// - threshold bits 13..0 hold the magnitude in source coding, bit 14 unused.
// - threshold bit 15 set means trigger above threshold, clear means below.
// - in rate mode the sample count register gives how many deltas are averaged.
// - in rate mode new minus previous sample forms a delta, the mean is compared.
// - control bits 15..12 select the alarm two source, 0 disabled, 1..11 sources.
// - control bits 11..8 select the alarm one source with the same codes.
// - control bit 7 puts alarm two in rate mode, else static level mode.
// - control bit 6 puts alarm one in rate mode, else static level mode.
// - control bit 2 enables the alarm pin output, else no pin is driven.
// - control bit 1 high makes the pin high while active, low makes it low.
// - control bit 0 set uses the second general pin, clear the first.
// - status bit 9 shows alarm two active and bit 8 alarm one active.
// - a status read clears the flags; a lasting condition sets them next update.
module dacm_monitor #(
  parameter int DW   = 14,
  parameter int NSRC = 11
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic             i_update,
  input  wire logic [NSRC*DW-1:0] i_src_raw,
  input  wire logic [NSRC*DW-1:0] i_src_filt,
  input  wire logic             i_reg_wr,
  input  wire logic             i_reg_rd,
  input  wire logic [6:0]       i_reg_addr,
  input  wire logic [15:0]      i_reg_wdata,
  output logic      [15:0]      o_reg_rdata,
  output logic      [1:0]       o_alarm_status,
  output logic                  o_general_pin_first_out,
  output logic                  o_general_pin_first_oe,
  output logic                  o_general_pin_second_out,
  output logic                  o_general_pin_second_oe
);

  if (DW < 2 || DW > 14 || NSRC < 1 || NSRC > 11) begin : g_bad_param
    $error("dacm_monitor: DW must be 2..14 and NSRC 1..11");
  end

  logic [15:0] thr_reg [2];
  logic [15:0] thr_next [2];
  logic [15:0] cnt_reg [2];
  logic [15:0] cnt_next [2];
  logic [15:0] ctl_reg, ctl_next;
  logic [1:0]  flag_reg, flag_next;
  logic [15:0] rdata_reg, rdata_next;
  logic        p1_out_reg, p1_out_next, p1_oe_reg, p1_oe_next;
  logic        p2_out_reg, p2_out_next, p2_oe_reg, p2_oe_next;

  logic [1:0]  eval_w, cond_w, roc_w;
  logic [3:0]  src_code [2];
  logic        status_rd, active;

  assign status_rd = i_reg_rd && (i_reg_addr == dacm_pkg::OFS_STATUS);

  // source code fields; code 0 or past the last source disables an alarm
  assign src_code[0] = ctl_reg[dacm_pkg::CTL_SRC_ONE_LSB +:
                               dacm_pkg::CTL_SRC_W];
  assign src_code[1] = ctl_reg[dacm_pkg::CTL_SRC_TWO_LSB +:
                               dacm_pkg::CTL_SRC_W];
  assign roc_w[0] = ctl_reg[dacm_pkg::CTL_ROC_ONE_BIT];
  assign roc_w[1] = ctl_reg[dacm_pkg::CTL_ROC_TWO_BIT];

  // one evaluator per alarm, each with its own source and settings
  for (genvar a = 0; a < 2; a++) begin : g_alarm
    logic [DW-1:0] smp;
    logic          en;

    // source pick; the filter choice is shared by both alarms
    always_comb begin
      smp = '0;
      en  = (src_code[a] != dacm_pkg::SRC_DISABLED) &&
            (src_code[a] <= dacm_pkg::SRC_LAST) &&
            (int'(src_code[a]) <= NSRC);
      for (int s = 0; s < NSRC; s++) begin
        if (int'(src_code[a]) == s + 1) begin
          smp = ctl_reg[dacm_pkg::CTL_FILT_BIT]
              ? i_src_filt[s*DW +: DW] : i_src_raw[s*DW +: DW];
        end
      end
    end

    dacm_alarm_chan #(.DW(DW)) u_chan (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .i_update  (i_update),
      .i_enable  (en),
      .i_roc     (roc_w[a]),
      .i_greater (thr_reg[a][dacm_pkg::THR_DIR_BIT]),
      .i_thr     (thr_reg[a][DW-1:0]),
      .i_count   (cnt_reg[a]),
      .i_sample  (smp),
      .o_eval    (eval_w[a]),
      .o_cond    (cond_w[a])
    );
  end

  // any live condition drives the pin; flags are for software only
  assign active = |cond_w;

  // register file, status flags, read data and pin drive
  always_comb begin
    thr_next    = thr_reg;
    cnt_next    = cnt_reg;
    ctl_next    = ctl_reg;
    flag_next   = flag_reg;
    rdata_next  = rdata_reg;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        dacm_pkg::OFS_ALARM_ONE_THRESHOLD:    thr_next[0] = i_reg_wdata;
        dacm_pkg::OFS_ALARM_TWO_THRESHOLD:    thr_next[1] = i_reg_wdata;
        dacm_pkg::OFS_ALARM_ONE_SAMPLE_COUNT: cnt_next[0] = i_reg_wdata;
        dacm_pkg::OFS_ALARM_TWO_SAMPLE_COUNT: cnt_next[1] = i_reg_wdata;
        dacm_pkg::OFS_ALARM_CONTROL:          ctl_next    = i_reg_wdata;
        default: ;                                 // others ignored
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        dacm_pkg::OFS_ALARM_ONE_THRESHOLD:    rdata_next = thr_reg[0];
        dacm_pkg::OFS_ALARM_TWO_THRESHOLD:    rdata_next = thr_reg[1];
        dacm_pkg::OFS_ALARM_ONE_SAMPLE_COUNT: rdata_next = cnt_reg[0];
        dacm_pkg::OFS_ALARM_TWO_SAMPLE_COUNT: rdata_next = cnt_reg[1];
        dacm_pkg::OFS_ALARM_CONTROL:          rdata_next = ctl_reg;
        dacm_pkg::OFS_STATUS: begin
          rdata_next = 16'h0000;
          rdata_next[dacm_pkg::STS_ALARM_ONE_BIT] = flag_reg[0];
          rdata_next[dacm_pkg::STS_ALARM_TWO_BIT] = flag_reg[1];
        end
        default: rdata_next = 16'h0000;
      endcase
    end
    // read clears, but a fresh hit in the same cycle is kept
    if (status_rd) begin
      flag_next = 2'b00;
    end
    flag_next = flag_next | (eval_w & cond_w);
    // pins: disabled output releases both lines
    p1_oe_next  = ctl_reg[dacm_pkg::CTL_OUT_EN_BIT] &&
                  !ctl_reg[dacm_pkg::CTL_OUT_SEL_BIT];
    p2_oe_next  = ctl_reg[dacm_pkg::CTL_OUT_EN_BIT] &&
                  ctl_reg[dacm_pkg::CTL_OUT_SEL_BIT];
    p1_out_next = p1_oe_next &&
                  (active == ctl_reg[dacm_pkg::CTL_OUT_POL_BIT]);
    p2_out_next = p2_oe_next &&
                  (active == ctl_reg[dacm_pkg::CTL_OUT_POL_BIT]);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      thr_reg[0] <= dacm_pkg::RST_THRESHOLD;
      thr_reg[1] <= dacm_pkg::RST_THRESHOLD;
      cnt_reg[0] <= dacm_pkg::RST_SAMPLE_COUNT;
      cnt_reg[1] <= dacm_pkg::RST_SAMPLE_COUNT;
      ctl_reg    <= dacm_pkg::RST_CONTROL;
      flag_reg   <= 2'b00;
      rdata_reg  <= 16'h0000;
      p1_out_reg <= 1'b0;
      p1_oe_reg  <= 1'b0;
      p2_out_reg <= 1'b0;
      p2_oe_reg  <= 1'b0;
    end else begin
      thr_reg    <= thr_next;
      cnt_reg    <= cnt_next;
      ctl_reg    <= ctl_next;
      flag_reg   <= flag_next;
      rdata_reg  <= rdata_next;
      p1_out_reg <= p1_out_next;
      p1_oe_reg  <= p1_oe_next;
      p2_out_reg <= p2_out_next;
      p2_oe_reg  <= p2_oe_next;
    end
  end

  assign o_reg_rdata              = rdata_reg;
  assign o_alarm_status           = flag_reg;
  assign o_general_pin_first_out  = p1_out_reg;
  assign o_general_pin_first_oe   = p1_oe_reg;
  assign o_general_pin_second_out = p2_out_reg;
  assign o_general_pin_second_oe  = p2_oe_reg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_hit_one;
    eval_w[0] && cond_w[0];
  endsequence

  sequence s_enabled_update_one;
    i_update && (src_code[0] != dacm_pkg::SRC_DISABLED) &&
    (src_code[0] <= dacm_pkg::SRC_LAST);
  endsequence

  a_flag_set_wins: assert property (s_hit_one |=> o_alarm_status[0])
    else $error("alarm one flag lost on hit");

  sequence s_hit_two;
    eval_w[1] && cond_w[1];
  endsequence

  // sticky flags: set on a hit, cleared only by a status read
  a_flag_two_set: assert property (s_hit_two |=> o_alarm_status[1])
    else $error("alarm two flag lost on hit");

  a_flag_read_clear: assert property (
    status_rd && !(eval_w[1] && cond_w[1]) |=> !o_alarm_status[1])
    else $error("status read did not clear alarm two flag");

  a_flag_one_clear: assert property (
    status_rd && !(eval_w[0] && cond_w[0]) |=> !o_alarm_status[0])
    else $error("status read did not clear alarm one flag");

  a_flag_hold: assert property (
    !status_rd && o_alarm_status[0] |=> o_alarm_status[0])
    else $error("alarm one flag dropped without a read");

  // evaluation timing; back-to-back updates keep eval high on purpose
  a_eval_per_update: assert property (
    s_enabled_update_one |=> eval_w[0] ##1 (!eval_w[0] || $past(i_update)))
    else $error("alarm one not evaluated once per update");

  a_eval_no_update: assert property (
    !i_update |=> !eval_w[0] && !eval_w[1])
    else $error("alarm evaluated without an update");

  // source decode: code 0 and codes past the last source both switch off
  a_src_disabled: assert property (
    i_update && (src_code[1] == dacm_pkg::SRC_DISABLED) |=> !eval_w[1] &&
    !cond_w[1])
    else $error("disabled alarm two evaluated");

  a_src_past_last: assert property (
    src_code[1] > dacm_pkg::SRC_LAST |=> !eval_w[1] && !cond_w[1])
    else $error("out of range alarm two source evaluated");

  a_src_one_off: assert property (
    src_code[0] == dacm_pkg::SRC_DISABLED |=> !eval_w[0] && !cond_w[0])
    else $error("disabled alarm one still active");

  // pin drive: enable, line select and polarity
  a_pin_disabled: assert property (
    !ctl_reg[dacm_pkg::CTL_OUT_EN_BIT] |=> !o_general_pin_first_oe &&
    !o_general_pin_second_oe)
    else $error("pin driven while output disabled");

  a_pin_select: assert property (
    ctl_reg[dacm_pkg::CTL_OUT_EN_BIT] && ctl_reg[dacm_pkg::CTL_OUT_SEL_BIT]
    |=> o_general_pin_second_oe && !o_general_pin_first_oe)
    else $error("wrong alarm line selected");

  a_pin_first_sel: assert property (
    ctl_reg[dacm_pkg::CTL_OUT_EN_BIT] && !ctl_reg[dacm_pkg::CTL_OUT_SEL_BIT]
    |=> o_general_pin_first_oe && !o_general_pin_second_oe)
    else $error("first alarm line not selected");

  a_pin_polarity: assert property (
    p1_oe_next && active && !ctl_reg[dacm_pkg::CTL_OUT_POL_BIT]
    |=> !o_general_pin_first_out)
    else $error("active low alarm pin not low");

  a_pin_high_act: assert property (
    p2_oe_next && active && ctl_reg[dacm_pkg::CTL_OUT_POL_BIT]
    |=> o_general_pin_second_out)
    else $error("active high alarm pin not high");

  // register port: status layout and stored writes
  a_status_read: assert property (
    status_rd |=> o_reg_rdata[dacm_pkg::STS_ALARM_TWO_BIT] ==
    $past(flag_reg[1]) && o_reg_rdata[dacm_pkg::STS_ALARM_ONE_BIT] ==
    $past(flag_reg[0]))
    else $error("status read data wrong");

  a_status_zero: assert property (
    status_rd |=> o_reg_rdata[15:10] == 6'h00 && o_reg_rdata[7:0] == 8'h00)
    else $error("status read shows bits outside the alarm flags");

  a_ctl_write: assert property (
    i_reg_wr && i_reg_addr == dacm_pkg::OFS_ALARM_CONTROL
    |=> ctl_reg == $past(i_reg_wdata))
    else $error("control write not stored");

  a_thr_write: assert property (
    i_reg_wr && i_reg_addr == dacm_pkg::OFS_ALARM_ONE_THRESHOLD
    |=> thr_reg[0] == $past(i_reg_wdata))
    else $error("threshold write not stored");

  a_cnt_write: assert property (
    i_reg_wr && i_reg_addr == dacm_pkg::OFS_ALARM_TWO_SAMPLE_COUNT
    |=> cnt_reg[1] == $past(i_reg_wdata))
    else $error("sample count write not stored");

endmodule // dacm_monitor

// ---- tb/dacm_host_model.sv ----
/*
  Host processor model driving decoded 16-bit register accesses.
  Assumes the monitor takes a strobe on the rising edge of i_ref_clk and
  answers a read with registered data one cycle later.
*/
`timescale 1ns/1ps
module dacm_host_model (
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_rdata,
  output logic             o_wr,
  output logic             o_rd,
  output logic [6:0]       o_addr,
  output logic [15:0]      o_wdata
);
  // idle bus at time zero
  initial begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 7'h00;
    o_wdata = 16'h0000;
  end

  // one-cycle write; data is inverted after release so stale data never helps
  task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
    @(negedge i_ref_clk);
    o_wr    = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_ref_clk);
    o_wr    = 1'b0;
    o_wdata = ~d;
  endtask

  // one-cycle read; rdata is taken once the strobe edge has landed
  task automatic reg_read(input logic [6:0] a, output logic [15:0] d);
    @(negedge i_ref_clk);
    o_rd   = 1'b1;
    o_addr = a;
    @(negedge i_ref_clk);
    o_rd   = 1'b0;
    d      = i_rdata;
  endtask
endmodule // dacm_host_model

// ---- tb/dacm_monitor_tb_top.sv ----
/*
  Self-checking bench for the dual alarm monitor with a behavioural model.
  Assumes the hand-over latencies: flag and pin two edges after an update.
*/
`timescale 1ns/1ps
module dacm_monitor_tb_top;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         upd = 1'b0;
  logic [153:0] raw_bus = '0;
  logic [153:0] filt_bus = '0;
  logic         wr, rd;
  logic [6:0]   addr;
  logic [15:0]  wdata, rdata, d;
  logic [1:0]   sts;
  logic         f_out, f_oe, s_out, s_oe;
  int fail_count = 0, comparisons = 0, cycles = 0, seed = 67665;
  int prv[2], sm[2], ct[2], raw[11], filt[11];
  bit hp[2], cnd[2], flg[2];
  logic [15:0] ctl, thr[2], ns[2];
  logic [6:0]  ofs[5];

  dacm_monitor dacm_monitor_inst (.i_ref_clk(clk), .i_rst(rst),
    .i_update(upd), .i_src_raw(raw_bus), .i_src_filt(filt_bus),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_alarm_status(sts),
    .o_general_pin_first_out(f_out), .o_general_pin_first_oe(f_oe),
    .o_general_pin_second_out(s_out), .o_general_pin_second_oe(s_oe));
  dacm_host_model dacm_host_model_inst (.i_ref_clk(clk), .i_rdata(rdata),
    .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));

  // 50 MHz clock
  always #10 clk = ~clk;

  // hang guard, far above the roughly 1300 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // write all alarm registers, then read each back
  task automatic cfg(input logic [15:0] c, input logic [15:0] t0,
                     input logic [15:0] t1, input logic [15:0] n0,
                     input logic [15:0] n1);
    logic [15:0] v[5];
    v = '{t0, t1, n0, n1, c};
    ctl = c;
    thr = '{t0, t1};
    ns = '{n0, n1};
    for (int i = 0; i < 5; i++) dacm_host_model_inst.reg_write(ofs[i], v[i]);
    for (int i = 0; i < 5; i++) begin
      dacm_host_model_inst.reg_read(ofs[i], d);
      chk_reg(d, v[i]);
    end
  endtask

  // one update with fresh samples, model step, then flag and pin checks
  task automatic do_update();
    int src, s, t, n;
    bit act;
    bit lvl;
    @(negedge clk);
    for (int k = 0; k < 11; k++) begin
      raw[k] = $random(seed) % 8192;
      filt[k] = $random(seed) % 8192;
      raw_bus[k*14 +: 14] = raw[k][13:0];
      filt_bus[k*14 +: 14] = filt[k][13:0];
    end
    upd = 1'b1;
    for (int a = 0; a < 2; a++) begin
      src = a ? ctl[15:12] : ctl[11:8];
      if (src == 0 || src > 11) begin
        hp[a] = 0;
        sm[a] = 0;
        ct[a] = 0;
        cnd[a] = 0;
      end else begin
        s = ctl[4] ? filt[src-1] : raw[src-1];
        t = int'($signed(thr[a][13:0]));
        n = (ns[a] == 0) ? 1 : int'(ns[a]);
        if (ctl[6+a]) begin
          if (hp[a]) begin
            sm[a] += s - prv[a];
            ct[a]++;
            if (ct[a] >= n) begin
              cnd[a] = thr[a][15] ? (sm[a] > t*n) : (sm[a] < t*n);
              sm[a] = 0;
              ct[a] = 0;
            end
          end
        end else cnd[a] = thr[a][15] ? (s > t) : (s < t);
        prv[a] = s;
        hp[a] = 1;
      end
      flg[a] |= cnd[a];
    end
    @(negedge clk);
    upd = 1'b0;
    repeat (2) @(negedge clk);
    act = cnd[0] | cnd[1];
    lvl = ctl[1] ? act : ~act;
    chk_flag(sts, {flg[1], flg[0]});
    chk_pin({f_oe, s_oe, f_oe & f_out, s_oe & s_out},
            {ctl[2] & ~ctl[0], ctl[2] & ctl[0], ctl[2] & ~ctl[0] & lvl,
             ctl[2] & ctl[0] & lvl});
  endtask

  // status read reports both flags and clears them
  task automatic clr_status();
    dacm_host_model_inst.reg_read(dacm_pkg::OFS_STATUS, d);
    chk_reg(d, {6'h00, flg[1], flg[0], 8'h00});
    flg = '{0, 0};
    chk_flag(sts, 2'h0);
  endtask

  // main sequence: reset values, unmapped places, static and rate sweeps
  initial begin
    logic [15:0] r;
    ofs = '{dacm_pkg::OFS_ALARM_ONE_THRESHOLD, dacm_pkg::OFS_ALARM_TWO_THRESHOLD,
            dacm_pkg::OFS_ALARM_ONE_SAMPLE_COUNT,
            dacm_pkg::OFS_ALARM_TWO_SAMPLE_COUNT, dacm_pkg::OFS_ALARM_CONTROL};
    hp = '{0, 0};
    cnd = '{0, 0};
    flg = '{0, 0};
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      dacm_host_model_inst.reg_read(ofs[i], d);
      chk_reg(d, 16'h0000);
    end
    dacm_host_model_inst.reg_read(7'h30, d);
    chk_reg(d, 16'h0000);
    dacm_host_model_inst.reg_write(7'h27, 16'hFFFF);
    dacm_host_model_inst.reg_read(7'h26, d);
    chk_reg(d, 16'h0000);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      // second half also sends codes 12..15, which must act as disabled
      cfg({4'(11 - i % 12 + i / 12 * 4), 4'(i % 12), 3'h0, r[4], 1'b0,
           r[2:0]},
          {r[15], 1'b0, 14'($random(seed))},
          {r[14], 1'b0, 14'($random(seed))}, 16'h0000, 16'h0000);
      repeat (2) do_update();
      clr_status();
    end
    for (int i = 0; i < 8; i++) begin
      cfg(16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
      do_update();
      r = $random(seed);
      cfg({4'(1 + i), 4'(11 - i), 2'h3, 1'b0, r[4], 1'b0, r[2:0]},
          {r[15], 1'b0, 14'($random(seed) % 64)},
          {r[14], 1'b0, 14'($random(seed) % 64)},
          16'(r[9:8]), 16'(r[11:10]));
      repeat (6) do_update();
      clr_status();
    end
    end_sim();
  end
endmodule // dacm_monitor_tb_top
